//--- verilog/sopd_decoder.sv
// Purpose: Decodes 128-bit native instructions and resolves their operands.
// Assumes: One instruction per cycle from the fetch path on aclk.
// Notes: Results appear one cycle after the instruction is taken.
//
// Operation
// - Up to three sources and one destination, each naming a register region.
// - Sources take negate, absolute and swizzle; destination takes a write mask.
// - Conditional modifier may write an implied flag register as second destination.
// - Every channel has a wide accumulator kept separately for each thread.
// - Accumulator loads by plain move or by arithmetic results.
// - Indirect location is address sub-register plus offset; only src0 and dst.
// - One address register of eight 16-bit unsigned sub-registers.
// - First two sub-registers form the message descriptor doubleword.
// - Two sources: only src1 immediate; one source: src0 may be immediate.
// - Scalar immediate up to 32 bits is replicated over all channels.
// - Packed immediates: eight signed 4-bit or four 8-bit restricted floats.
// - Channels limited by write mask, predicate, execution mask and width.
// - Native words are fixed 128 bits; a 64-bit compact form exists.
// - Only 120 bits carry meaning; the rest are reserved.
// - Lowest doubleword holds opcode and general controls.
// - Second doubleword holds destination plus source register files and types.
// - Third doubleword is src0; fourth is src1 and any 32-bit immediate.
// - Common format fields differ by addressing kind and access layout.
// - Three-source sub-register numbers count doublewords.
// - Three-source uses four-channel layout with swizzle and replication.
// - Bits 31:0 keep one layout for every instruction.
// - Condition modifier zero leaves all flag registers unchanged.
// - Three-source format serves extract, insert, interpolate and multiply-add.
`timescale 1ns/10ps

module sopd_decoder
  import sopd_pkg::*;
#(
  parameter int NCH = CHANNELS,
  parameter int ACC_W = ACC_WIDTH,
  parameter int NTHR = THREADS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [127:0] instr_word,
  input wire logic [$clog2(NTHR)-1:0] instr_thread,
  input wire logic [NCH-1:0] flag_value,
  input wire logic acc_wr_en,
  input wire logic [$clog2(NTHR)-1:0] acc_wr_thread,
  input wire logic acc_wr_mov,
  input wire logic [NCH-1:0] acc_wr_mask,
  input wire logic [NCH-1:0][ACC_W-1:0] acc_wr_data,
  output logic dec_valid,
  output sopd_decoded_type dec,
  output logic [NCH-1:0] chan_en,
  output logic [NCH-1:0][31:0] imm_vec,
  output logic [NCH-1:0][ACC_W-1:0] acc_rd_data,
  output logic [31:0] msg_desc
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic aw_held;
    logic [AXI_AW-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NCH-1:0] exec_mask;
    sopd_areg_type areg;
    logic ready;
    logic dvalid;
    sopd_decoded_type dec;
    logic [NCH-1:0] chan_en;
    logic [31:0] imm_raw;
  } sopd_state_type;

  sopd_state_type q;
  sopd_state_type n;
  logic take;
  logic [2:0] imm_ty;

  // ==========================================================================
  // Decode helpers
  function automatic logic [12:0] ind_loc(input sopd_areg_type ar, input logic [2:0] idx,
                                          input logic [9:0] ofs);
    ind_loc = ar[idx][12:0] + {{3{ofs[9]}}, ofs};
  endfunction

  function automatic logic is_three(input logic [6:0] op);
    is_three = (op == OP_FIELD_EXTRACT) || (op == OP_FIELD_INSERT) ||
               (op == OP_LERP) || (op == OP_MUL_ADD);
  endfunction

  function automatic sopd_operand_type dec_src(input logic [127:0] w, input int ofs,
                                               input logic [1:0] rf, input logic [2:0] ty,
                                               input logic a16, input logic ind_ok,
                                               input sopd_areg_type ar);
    sopd_operand_type o;
    logic [9:0] offs;
    logic [12:0] loc;
    o = '0;
    o.rf = rf;
    o.ty = ty;
    o.abs = w[S0MOD_L + ofs];
    o.neg = w[S0MOD_L + ofs + 1];
    o.ind = w[S0AM_B + ofs] & ind_ok;
    o.swz = a16 ? {w[S0CH_HI_L + ofs +: 4], w[S0SUB_L + ofs +: 4]} : SWZ_IDENTITY;
    offs = a16 ? {w[S0SUB_L + ofs + 4 +: 6], 4'h0} : w[S0SUB_L + ofs +: 10];
    loc = ind_loc(ar, w[S0ASUB_L + ofs +: 3], offs);
    if (o.ind) begin
      o.regnum = loc[12:5];
      o.sub = loc[4:0];
    end else begin
      o.regnum = w[S0REG_L + ofs +: 8];
      o.sub = a16 ? {w[S0SUB_L + ofs + 4], 4'h0} : w[S0SUB_L + ofs +: 5];
    end
    dec_src = o;
  endfunction

  function automatic sopd_operand_type dec_three(input logic [127:0] w, input int grp,
                                                 input logic [2:0] ty);
    sopd_operand_type o;
    int base;
    o = '0;
    base = T_SRC_L + grp * T_GRP_W;
    o.rf = RF_GRF;
    o.ty = ty;
    o.rep = w[base];
    o.swz = w[base + 1 +: 8];
    o.sub = {w[base + 9 +: 3], 2'h0};
    o.regnum = w[base + 12 +: 8];
    o.abs = w[T_MOD_L + 2 * grp];
    o.neg = w[T_MOD_L + 2 * grp + 1];
    dec_three = o;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b * 8 +: 8] = nw[b * 8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic is_areg(input logic [AXI_AW-1:0] a);
    is_areg = a[7:5] == REG_ADDR0[7:5];
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic [127:0] w;
    logic [31:0] cw;
    logic [3:0] wm;
    logic [NCH-1:0] pm;
    logic [2:0] dty;
    logic [9:0] doffs;
    logic [12:0] dloc;
    w = instr_word;
    cw = '0;
    wm = '0;
    pm = '0;
    dty = '0;
    doffs = '0;
    dloc = '0;
    n = q;
    n.dvalid = 1'b0;
    take = instr_valid && q.ready;
    imm_ty = '0;

    // Register bus, write side.
    if (s_axi_awvalid && q.awready) begin
      n.aw_held = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_held && n.w_held && !q.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      if (n.awaddr[7:2] == REG_CTRL[7:2]) begin
        cw = merge(32'(q.exec_mask), n.wdata, n.wstrb);
        n.exec_mask = cw[NCH-1:0];
      end else if (is_areg(n.awaddr)) begin
        cw = merge({16'h0, q.areg[n.awaddr[4:2]]}, n.wdata, n.wstrb);
        n.areg[n.awaddr[4:2]] = cw[15:0];
      end else if (n.awaddr[7:2] != REG_STATUS[7:2] && n.awaddr[7:2] != REG_CHAN[7:2] &&
                   n.awaddr[7:2] != REG_DESC[7:2] && n.awaddr[7:2] != REG_IMM[7:2]) begin
        n.bresp = RESP_DECERR;
      end
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;

    // Register bus, read side.
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      if (is_areg(s_axi_araddr)) begin
        n.rdata = {16'h0, q.areg[s_axi_araddr[4:2]]};
      end else begin
        unique case (s_axi_araddr[7:2])
          REG_CTRL[7:2]: n.rdata = 32'(q.exec_mask);
          REG_STATUS[7:2]: n.rdata = {16'h0, q.dec.flag_wr, q.dec.imm_ok, q.dec.a16,
                                      q.dec.three, q.dec.nsrc, q.dec.exec, q.dec.opcode};
          REG_CHAN[7:2]: n.rdata = 32'(q.chan_en);
          REG_DESC[7:2]: n.rdata = {q.areg[1], q.areg[0]};
          REG_IMM[7:2]: n.rdata = q.imm_raw;
          default: n.rresp = RESP_DECERR;
        endcase
      end
    end else if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    n.arready = !n.rvalid;
    n.ready = 1'b1;

    // Instruction decode. Reserved bits are never looked at.
    if (take) begin
      n.dvalid = 1'b1;
      n.imm_raw = w[IMM_L +: 32];
      n.dec = '0;
      n.dec.opcode = w[OPC_L +: 7];
      n.dec.a16 = w[ALIGN_B];
      n.dec.exec = w[EXEC_L +: 3];
      n.dec.sat = w[SAT_B];
      n.dec.cond = w[COND_L +: 4];
      n.dec.flag_wr = w[COND_L +: 4] != COND_NONE;
      n.dec.three = is_three(w[OPC_L +: 7]);
      if (n.dec.three) begin
        n.dec.nsrc = 2'h3;
        n.dec.a16 = 1'b1;
        n.dec.freg = w[T_FREG_B];
        n.dec.fsub = w[T_FSUB_B];
        n.dec.wmask = w[T_DCH_L +: 4];
        n.dec.dst.rf = RF_GRF;
        n.dec.dst.ty = {1'b0, w[T_DTY_L +: 2]};
        n.dec.dst.regnum = w[T_DREG_L +: 8];
        n.dec.dst.sub = {w[T_DSUB_L +: 3], 2'h0};
        n.dec.src0 = dec_three(w, 0, {1'b0, w[T_STY_L +: 2]});
        n.dec.src1 = dec_three(w, 1, {1'b0, w[T_STY_L +: 2]});
        n.dec.src2 = dec_three(w, 2, {1'b0, w[T_STY_L +: 2]});
      end else begin
        n.dec.nsrc = (w[OPC_L +: 7] < ONE_SRC_LIMIT) ? 2'h1 : 2'h2;
        n.dec.freg = w[FREG_B];
        n.dec.fsub = w[FSUB_B];
        // Destination and source file and type fields share the second dword.
        n.dec.dst.rf = w[DRF_L +: 2];
        dty = w[DTY_L +: 3];
        n.dec.dst.ty = dty;
        n.dec.dst.ind = w[DAM_B];
        n.dec.dst.swz = SWZ_IDENTITY;
        n.dec.wmask = n.dec.a16 ? w[DSUB_L +: 4] : 4'hF;
        doffs = n.dec.a16 ? {w[DREG_L - 1 +: 6], 4'h0} : w[DSUB_L +: 10];
        dloc = ind_loc(q.areg, w[DASUB_L +: 3], doffs);
        if (n.dec.dst.ind) begin
          n.dec.dst.regnum = dloc[12:5];
          n.dec.dst.sub = dloc[4:0];
        end else begin
          n.dec.dst.regnum = w[DREG_L +: 8];
          n.dec.dst.sub = n.dec.a16 ? {w[DREG_L - 1], 4'h0} : w[DSUB_L +: 5];
        end
        n.dec.src0 = dec_src(w, 0, w[S0RF_L +: 2], w[S0TY_L +: 3], n.dec.a16, 1'b1,
                             q.areg);
        n.dec.src1 = dec_src(w, SRC1_OFS, w[S1RF_L +: 2], w[S1TY_L +: 3], n.dec.a16,
                             1'b0, q.areg);
        // A 32-bit immediate always sits in the fourth dword.
        if (n.dec.nsrc == 2'h1) begin
          n.dec.imm_ok = n.dec.src0.rf == RF_IMM;
          n.dec.imm_slot = 1'b0;
          n.dec.src1 = '0;
          imm_ty = n.dec.src0.ty;
        end else begin
          n.dec.imm_ok = n.dec.src1.rf == RF_IMM && n.dec.src0.rf != RF_IMM;
          n.dec.imm_slot = 1'b1;
          imm_ty = n.dec.src1.ty;
        end
      end
      n.dec.acc_dst = w[ACCWR_B] ||
                      (n.dec.dst.rf == RF_ARF && n.dec.dst.regnum == ACC_REGNUM);
      n.dec.src2.swz = n.dec.three ? n.dec.src2.swz : SWZ_IDENTITY;
      wm = n.dec.wmask;
      if (w[PRED_L +: 4] == 4'h0) begin
        pm = '1;
      end else begin
        pm = flag_value ^ {NCH{w[PINV_B]}};
      end
      for (int i = 0; i < NCH; i++) begin
        n.chan_en[i] = (i < (1 << n.dec.exec)) && wm[i % 4] && pm[i] &&
                       q.exec_mask[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.exec_mask <= '1;
    end else begin
      q <= n;
    end
  end

  // ==========================================================================
  // Immediate expansion and accumulators
  sopd_imm_expand #(
    .NCH(NCH)
  ) u_imm (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(take && !is_three(instr_word[OPC_L +: 7])),
    .ty(imm_ty),
    .imm(instr_word[IMM_L +: 32]),
    .vec(imm_vec)
  );

  sopd_acc_bank #(
    .NCH(NCH),
    .ACC_W(ACC_W),
    .NTHR(NTHR)
  ) u_acc (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(acc_wr_en),
    .wr_thread(acc_wr_thread),
    .wr_mov(acc_wr_mov),
    .wr_mask(acc_wr_mask),
    .wr_data(acc_wr_data),
    .rd_en(take),
    .rd_thread(instr_thread),
    .rd_data(acc_rd_data)
  );

  // ==========================================================================
  // Outputs
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign instr_ready = q.ready;
  assign dec_valid = q.dvalid;
  assign dec = q.dec;
  assign chan_en = q.chan_en;
  assign msg_desc = {q.areg[1], q.areg[0]};

endmodule

//--- shared/sopd_pkg.sv
// Purpose: Shared constants and carrier types of the SIMD operand decoder.
// Assumes: 128-bit native instruction words; AXI4-Lite register access.
// Notes: Bit positions are the low bit of each instruction field.

package sopd_pkg;

  // ==========================================================================
  // Sizes
  localparam int CHANNELS = 8;
  localparam int ACC_WIDTH = 48;
  localparam int THREADS = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_SUBREGS = 8;
  localparam int ADDR_SUB_W = 16;
  localparam int AXI_AW = 8;

  // ==========================================================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CHAN = 8'h08;
  localparam logic [7:0] REG_DESC = 8'h0C;
  localparam logic [7:0] REG_IMM = 8'h10;
  localparam logic [7:0] REG_ADDR0 = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] RF_ARF = 2'h0;
  localparam logic [1:0] RF_GRF = 2'h1;
  localparam logic [1:0] RF_IMM = 2'h3;
  localparam logic [2:0] T_UW = 3'h2;
  localparam logic [2:0] T_W = 3'h3;
  localparam logic [2:0] T_UV = 3'h4;
  localparam logic [2:0] T_VF = 3'h5;
  localparam logic [2:0] T_V = 3'h6;
  localparam logic [3:0] COND_NONE = 4'h0;
  localparam logic [6:0] OP_FIELD_EXTRACT = 7'h18;
  localparam logic [6:0] OP_FIELD_INSERT = 7'h19;
  localparam logic [6:0] OP_LERP = 7'h5C;
  localparam logic [6:0] OP_MUL_ADD = 7'h5B;
  localparam logic [6:0] ONE_SRC_LIMIT = 7'h10;
  localparam logic [7:0] ACC_REGNUM = 8'h20;
  localparam logic [7:0] SWZ_IDENTITY = 8'hE4;
  localparam logic [7:0] VF_EXP_ADJ = 8'h7C;

  // ==========================================================================
  // Operation dword and common operand layout
  localparam int OPC_L = 0;
  localparam int ALIGN_B = 8;
  localparam int PRED_L = 16;
  localparam int PINV_B = 20;
  localparam int EXEC_L = 21;
  localparam int COND_L = 24;
  localparam int ACCWR_B = 28;
  localparam int SAT_B = 31;
  localparam int DRF_L = 32;
  localparam int DTY_L = 34;
  localparam int S0RF_L = 37;
  localparam int S0TY_L = 39;
  localparam int S1RF_L = 42;
  localparam int S1TY_L = 44;
  localparam int DSUB_L = 48;
  localparam int DREG_L = 53;
  localparam int DASUB_L = 58;
  localparam int DAM_B = 63;
  localparam int S0SUB_L = 64;
  localparam int S0REG_L = 69;
  localparam int S0ASUB_L = 74;
  localparam int S0MOD_L = 77;
  localparam int S0AM_B = 79;
  localparam int S0CH_HI_L = 80;
  localparam int FSUB_B = 89;
  localparam int FREG_B = 90;
  localparam int SRC1_OFS = 32;
  localparam int IMM_L = 96;

  // ==========================================================================
  // Three-source layout
  localparam int T_FSUB_B = 33;
  localparam int T_FREG_B = 34;
  localparam int T_MOD_L = 36;
  localparam int T_STY_L = 42;
  localparam int T_DTY_L = 44;
  localparam int T_DCH_L = 49;
  localparam int T_DSUB_L = 53;
  localparam int T_DREG_L = 56;
  localparam int T_SRC_L = 64;
  localparam int T_GRP_W = 21;

  typedef logic [ADDR_SUBREGS-1:0][ADDR_SUB_W-1:0] sopd_areg_type;

  typedef struct packed {
    logic [1:0] rf;
    logic [2:0] ty;
    logic ind;
    logic [7:0] regnum;
    logic [4:0] sub;
    logic neg;
    logic abs;
    logic [7:0] swz;
    logic rep;
  } sopd_operand_type;

  typedef struct packed {
    logic [6:0] opcode;
    logic [1:0] nsrc;
    logic three;
    logic a16;
    logic [2:0] exec;
    logic sat;
    logic acc_dst;
    logic [3:0] cond;
    logic flag_wr;
    logic freg;
    logic fsub;
    logic [3:0] wmask;
    logic imm_ok;
    logic imm_slot;
    sopd_operand_type dst;
    sopd_operand_type src0;
    sopd_operand_type src1;
    sopd_operand_type src2;
  } sopd_decoded_type;

endpackage

//--- verilog/sopd_imm_expand.sv
// Purpose: Turns a 32-bit immediate into one value per channel.
// Assumes: Type codes of the immediate slot; load aligned with decode.
// Notes: Output is registered.
`timescale 1ns/10ps

module sopd_imm_expand
  import sopd_pkg::*;
#(
  parameter int NCH = CHANNELS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [2:0] ty,
  input wire logic [31:0] imm,
  output logic [NCH-1:0][31:0] vec
);

  typedef struct packed {
    logic [NCH-1:0][31:0] vec;
  } sopd_imm_state_type;

  sopd_imm_state_type q;
  sopd_imm_state_type n;

  // Restricted float: sign, three exponent bits, four mantissa bits.
  function automatic logic [31:0] vf_to_f(input logic [7:0] b);
    logic [7:0] e;
    e = {5'h0, b[6:4]} + VF_EXP_ADJ;
    if (b[6:0] == 7'h00) begin
      vf_to_f = {b[7], 31'h0};
    end else begin
      vf_to_f = {b[7], e, b[3:0], 19'h0};
    end
  endfunction

  always_comb begin
    n = q;
    if (load) begin
      for (int i = 0; i < NCH; i++) begin
        unique case (ty)
          T_V: n.vec[i] = {{28{imm[(i % 8) * 4 + 3]}}, imm[(i % 8) * 4 +: 4]};
          T_UV: n.vec[i] = {28'h0, imm[(i % 8) * 4 +: 4]};
          T_VF: n.vec[i] = vf_to_f(imm[(i % 4) * 8 +: 8]);
          T_W: n.vec[i] = {{16{imm[15]}}, imm[15:0]};
          T_UW: n.vec[i] = {16'h0, imm[15:0]};
          default: n.vec[i] = imm;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign vec = q.vec;

endmodule

//--- verilog/sopd_acc_bank.sv
// Purpose: Per-thread, per-channel accumulator storage.
// Assumes: Results arrive already widened; moves carry 32-bit data.
// Notes: A read in the cycle of a write to the same thread sees old data.
`timescale 1ns/10ps

module sopd_acc_bank
  import sopd_pkg::*;
#(
  parameter int NCH = CHANNELS,
  parameter int ACC_W = ACC_WIDTH,
  parameter int NTHR = THREADS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [$clog2(NTHR)-1:0] wr_thread,
  input wire logic wr_mov,
  input wire logic [NCH-1:0] wr_mask,
  input wire logic [NCH-1:0][ACC_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [$clog2(NTHR)-1:0] rd_thread,
  output logic [NCH-1:0][ACC_W-1:0] rd_data
);

  typedef struct packed {
    logic [NTHR-1:0][NCH-1:0][ACC_W-1:0] mem;
    logic [NCH-1:0][ACC_W-1:0] rd;
  } sopd_acc_state_type;

  sopd_acc_state_type q;
  sopd_acc_state_type n;

  always_comb begin
    n = q;
    if (wr_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_mask[i] && wr_mov) begin
          n.mem[wr_thread][i] = {{(ACC_W-DATA_W){wr_data[i][DATA_W-1]}},
                                 wr_data[i][DATA_W-1:0]};
        end else if (wr_mask[i]) begin
          n.mem[wr_thread][i] = wr_data[i];
        end
      end
    end
    if (rd_en) begin
      n.rd = q.mem[rd_thread];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rd_data = q.rd;

endmodule

//--- tb/sopd_decoder_props.sv
// Purpose: Port assertions for the decoder.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to the top module below.
`timescale 1ns/10ps
module sopd_decoder_props
  import sopd_pkg::*;
#(
  parameter int NCH = CHANNELS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [127:0] instr_word,
  input wire logic dec_valid,
  input wire sopd_decoded_type dec,
  input wire logic [NCH-1:0] chan_en
);
  // ==========
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_take; instr_valid && instr_ready |=> dec_valid; endproperty
  a_take: assert property (p_take) else $error("no decode");
  property p_idle; !(instr_valid && instr_ready) |=> !dec_valid; endproperty
  a_idle: assert property (p_idle) else $error("spurious decode");
  property p_op; logic [6:0] op;
    (instr_valid && instr_ready, op = instr_word[6:0]) |=> dec.opcode == op; endproperty
  a_op: assert property (p_op) else $error("opcode wrong");
  property p_cond; dec_valid && dec.cond == COND_NONE |-> !dec.flag_wr; endproperty
  a_cond: assert property (p_cond) else $error("flag written");
  property p_a16; dec_valid && dec.three |-> dec.a16; endproperty
  a_a16: assert property (p_a16) else $error("layout wrong");
  property p_sub; dec_valid && dec.three |-> dec.src0.sub[1:0] == 2'h0; endproperty
  a_sub: assert property (p_sub) else $error("sub not dword");
  property p_width; dec_valid |-> (chan_en >> (1 << dec.exec)) == '0; endproperty
  a_width: assert property (p_width) else $error("width exceeded");
  property p_mask; dec_valid |-> (chan_en & ~{2{dec.wmask}}) == '0; endproperty
  a_mask: assert property (p_mask) else $error("mask ignored");
  property p_imm; dec_valid && dec.nsrc == 2'h2 && dec.src0.rf == RF_IMM |-> !dec.imm_ok;
  endproperty
  a_imm: assert property (p_imm) else $error("src0 immediate");
  c_three: cover property (dec_valid && dec.three);
  c_flag: cover property (dec_valid && dec.flag_wr);
  c_imm: cover property (dec_valid && dec.imm_ok);
endmodule
bind sopd_decoder sopd_decoder_props #(.NCH(NCH)) i_sopd_decoder_props (.*);

//--- tb/sopd_fetch_model.sv
// Purpose: Fetch path model feeding instruction words.
// Assumes: One word per request.
// Notes: Idle lines show the inverse of the last word.
`timescale 1ns/10ps
module sopd_fetch_model (
  input wire logic aclk,
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [127:0] instr_word,
  output logic [2:0] instr_thread
);
  initial begin
    instr_valid = 1'h0;
    instr_word = '0;
    instr_thread = 3'h0;
  end
  task automatic send(input logic [127:0] w, input logic [2:0] t);
    @(posedge aclk);
    instr_word <= {w[127:24], 1'h0, w[22:0]};
    instr_thread <= t;
    instr_valid <= 1'h1;
    do @(posedge aclk); while (!instr_ready);
    instr_valid <= 1'h0;
    instr_word <= ~instr_word;
    instr_thread <= ~t;
  endtask
endmodule

//--- tb/sopd_decoder_test.sv
// Purpose: Self-checking bench for the decoder.
// Assumes: Default parameters.
// Notes: Registers over AXI4-Lite, words through the fetch model.
`timescale 1ns/10ps
module sopd_decoder_test
  import sopd_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, acc_wr_en = 1'h0, acc_wr_mov = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, instr_valid, instr_ready, dec_valid;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, flag_value = 8'h5A, acc_wr_mask = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, acc_wr_thread = '0, instr_thread;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, msg_desc;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [127:0] instr_word, w;
  logic [7:0] chan_en;
  logic [7:0][47:0] acc_wr_data = '0, acc_rd_data;
  logic [7:0][31:0] imm_vec;
  logic [6:0] ops [4] = '{OP_FIELD_EXTRACT, OP_FIELD_INSERT, OP_LERP, OP_MUL_ADD};
  sopd_decoded_type dec;
  int n_fail = 0, compares = 0, i;
  sopd_decoder i_sopd_decoder (.*);
  sopd_fetch_model i_sopd_fetch_model (.*);
  always #4 aclk = ~aclk;
  // ==========
  // Tasks
  task chk(input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task complete_run;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask
  task run(input logic [127:0] x, input logic [2:0] t);
    i_sopd_fetch_model.send(x, t);
    #1;
    chk(dec_valid, 1'h1);
  endtask
  task acc(input logic [2:0] t, input logic m, input logic [47:0] d);
    @(posedge aclk);
    acc_wr_en <= 1'h1;
    acc_wr_thread <= t;
    acc_wr_mov <= m;
    acc_wr_mask <= 8'hFF;
    acc_wr_data <= {8{d}};
    @(posedge aclk);
    acc_wr_en <= 1'h0;
  endtask
  function automatic logic [127:0] ins(logic [6:0] op, logic [4:0] pr, logic [3:0] cd,
                                       logic [95:0] up);
    return {up, 4'h0, cd, 3'h3, pr, 9'h0, op};
  endfunction
  // ==========
  // Tests
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(REG_CTRL, 32'hFF, RESP_OKAY);
    wr(REG_ADDR0, 32'hFFFF1234, RESP_OKAY);
    wr(REG_ADDR0 + 8'h4, 32'hABCD, RESP_OKAY);
    rd(REG_ADDR0, 32'h1234, RESP_OKAY);
    rd(REG_DESC, 32'hABCD1234, RESP_OKAY);
    chk(msg_desc, 32'hABCD1234);
    wr(8'h40, 32'h1, RESP_DECERR);
    rd(8'h40, 32'h0, RESP_DECERR);
    $display("registers done");
    for (i = 0; i < 4; i++) begin
      w = ins(7'h1, 5'h0, 4'h0, 96'h0);
      w[23:21] = i[2:0];
      run(w, 3'h0);
      chk(chan_en, 8'hFF >> (8 - (1 << i)));
    end
    chk(dec.nsrc, 2'h1);
    run(ins(7'h1, 5'h01, 4'h1, 96'h0), 3'h0);
    chk(chan_en, 8'h5A);
    chk(dec.flag_wr, 1'h1);
    run(ins(7'h1, 5'h11, 4'h0, 96'h0), 3'h0);
    chk(chan_en, 8'hA5);
    wr(REG_CTRL, 32'hF, RESP_OKAY);
    run(ins(7'h1, 5'h0, 4'h0, 96'h0), 3'h0);
    chk(chan_en, 8'h0F);
    wr(REG_CTRL, 32'hFF, RESP_OKAY);
    $display("masking done");
    run(ins(7'h1, 5'h0, 4'h0, {32'hCAFE0001, 64'h60}), 3'h0);
    for (i = 0; i < 8; i++) chk(imm_vec[i], 32'hCAFE0001);
    w = ins(7'h40, 5'h0, 4'h0, {32'h89ABCDEF, 64'h6C00});
    run(w, 3'h0);
    chk(dec.imm_ok, 1'h1);
    for (i = 0; i < 8; i++) chk(imm_vec[i], {{28{w[99+4*i]}}, w[96+4*i+:4]});
    run(ins(7'h40, 5'h0, 4'h0, 96'h60), 3'h0);
    chk(dec.imm_ok, 1'h0);
    $display("immediates done");
    for (i = 0; i < 4; i++) begin
      run(ins(ops[i], 5'h0, 4'h0, 96'hA0000000000), 3'h0);
      chk(dec.three, 1'h1);
      chk(dec.src0.sub, 5'h14);
    end
    $display("three-source done");
    acc(3'h2, 1'h1, 48'h80000001);
    acc(3'h3, 1'h0, 48'h123456789ABC);
    run(ins(7'h1, 5'h0, 4'h0, 96'h800400000000), 3'h2);
    chk(acc_rd_data[0], 48'hFFFF80000001);
    chk(dec.src0[23:11], 13'h1238);
    run(ins(7'h1, 5'h0, 4'h0, 96'h0), 3'h3);
    chk(acc_rd_data[7], 48'h123456789ABC);
    $display("accumulators done");
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    complete_run;
  end
endmodule
